// ### sevr_status_event_registers.sv
// status event register bank: standard event, device event, error log and summaries
// Functional notes
// - set standard bit 0 when pending work ends after the completion command
// - set standard bit 3 on a hardware error
// - set standard bit 4 on non-runnable command or invalid parameter
// - set standard bit 5 on a misspelled command
// - set standard bit 7 after power cycled off and on
// - clear standard bits at power-on, clear-status and on query read
// - clear standard mask at power-on and when written zero
// - set device bits 0,1,2 on comparator high, pass, low
// - bit 5 follows suspend state; bit 11 follows operate state
// - set device bits 6,7 on limiter, bits 8,9 on external inputs
// - device bit 10 follows buffer full
// - device bit 12 set at calibration end, cleared at start
// - device bit 13 set at sweep end, cleared at start
// - bit 14 set on held step end outside burst; cleared step/sweep start/stop
// - bit 15 set at measurement end; cleared at start or data read
// - clear device bits at power-on; clear all but level bits 5, 10, 11 at clear-status and on query read
// - clear device mask at power-on and when written zero
// - set error bit 0 on power-on self-test failure, bit 1 on self-test failure
// - set error bits 3,4,5 on overload, fan stop, overheat; they stay set
// - set error bits 6, 9, 10 on source fault, calculation error, over-range
// - set error bits 12 to 15 on argument, execution, syntax, unknown errors
// - error log clears only at power-on or clear-status; reads keep it
// - summary is OR of event register ANDed with mask
// - status byte bit 3 carries the device summary
// - status byte bit 5 carries the standard summary
// - event registers take no writes, only set and clear actions
`timescale 1ns/10ps
`default_nettype none

module sevr_status_event_registers
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // command side, one-cycle pulses from the parser
    input wire logic i_clear_status,
    input wire logic i_std_read,
    input wire logic i_dev_read,
    input wire logic i_err_read,
    input wire logic i_std_mask_wr,
    input wire logic [sevr_pkg::SEVR_STD_W-1:0] i_std_mask_data,
    input wire logic i_dev_mask_wr,
    input wire logic [sevr_pkg::SEVR_DEV_W-1:0] i_dev_mask_data,
    // standard event sources, pulses
    input wire logic i_all_done_flag,
    input wire logic i_hardware_fault_flag,
    input wire logic i_command_not_runnable_flag,
    input wire logic i_bad_spelling_flag,
    input wire logic i_power_cycle_flag,
    // device event sources
    input wire logic i_comparator_above_flag,
    input wire logic i_comparator_pass_flag,
    input wire logic i_comparator_under_flag,
    input wire sevr_pkg::sevr_state_t i_op_state,
    input wire logic i_limiter_under_flag,
    input wire logic i_limiter_over_flag,
    input wire logic i_external_output_off_flag,
    input wire logic i_external_trigger_flag,
    input wire logic i_buffer_full_flag,
    input wire logic i_calibration_start,
    input wire logic i_calibration_done_flag,
    input wire logic i_scan_start,
    input wire logic i_scan_stop,
    input wire logic i_scan_done_flag,
    input wire logic i_step_start,
    input wire logic i_scan_step_done_flag,
    input wire logic i_trigger_hold,
    input wire logic i_burst_active,
    input wire logic i_measure_start,
    input wire logic i_measure_done_flag,
    input wire logic i_measure_data_read,
    // error sources
    input wire logic i_powerup_selftest_fail,
    input wire logic i_selftest_fail,
    input wire logic i_overload,
    input wire logic i_fan_stop,
    input wire logic i_overheat,
    input wire logic i_source_fault,
    input wire logic i_calc_error,
    input wire logic i_over_range,
    input wire logic i_arg_error,
    input wire logic i_exec_error,
    input wire logic i_syntax_error,
    input wire logic i_unknown_command,
    // read side
    output logic [sevr_pkg::SEVR_STD_W-1:0] o_std_rdata,
    output logic [sevr_pkg::SEVR_DEV_W-1:0] o_dev_rdata,
    output logic [sevr_pkg::SEVR_ERR_W-1:0] o_err_rdata,
    output logic [sevr_pkg::SEVR_STD_W-1:0] o_standard_event_reg,
    output logic [sevr_pkg::SEVR_DEV_W-1:0] o_device_event_register,
    output logic [sevr_pkg::SEVR_ERR_W-1:0] o_error_log,
    output logic [sevr_pkg::SEVR_STD_W-1:0] o_std_mask,
    output logic [sevr_pkg::SEVR_DEV_W-1:0] o_dev_mask,
    output logic o_device_summary_bit,
    output logic o_standard_summary_bit,
    output logic [7:0] o_status_byte_part
);
    import sevr_pkg::*;

    logic [SEVR_STD_W-1:0] std_reg, std_next, std_set;
    logic [SEVR_DEV_W-1:0] dev_reg, dev_next, dev_set, dev_clr;
    logic [SEVR_ERR_W-1:0] err_reg, err_next, err_set;
    logic [SEVR_STD_W-1:0] std_mask_reg, std_mask_next;
    logic [SEVR_DEV_W-1:0] dev_mask_reg, dev_mask_next;
    logic [SEVR_STD_W-1:0] std_rd_reg, std_rd_next;
    logic [SEVR_DEV_W-1:0] dev_rd_reg, dev_rd_next;
    logic [SEVR_ERR_W-1:0] err_rd_reg, err_rd_next;
    logic dsum_reg, dsum_next, ssum_reg, ssum_next;

    // enabled summary of an event word against its mask
    function automatic logic sevr_summary(input logic [15:0] ev, input logic [15:0] mask);
        sevr_summary = |(ev & mask);
    endfunction : sevr_summary

    // standard event sets; unused bits never set so they read zero
    always_comb
    begin
        std_set = '0;
        std_set[STD_ALL_DONE] = i_all_done_flag;
        std_set[STD_HW_FAULT] = i_hardware_fault_flag;
        std_set[STD_NOT_RUNNABLE] = i_command_not_runnable_flag;
        std_set[STD_BAD_SPELLING] = i_bad_spelling_flag;
        std_set[STD_POWER_CYCLE] = i_power_cycle_flag;
    end

    // standard event latch: clear on query or clear-status, set wins over read clear
    always_comb
    begin
        std_next = std_reg;
        if (i_clear_status || i_std_read)
        begin
            std_next = STD_RESET;
        end
        std_next = std_next | std_set;
    end

    // device event set and clear terms
    always_comb
    begin
        dev_set = '0;
        dev_clr = '0;
        dev_set[DEV_CMP_ABOVE] = i_comparator_above_flag;
        dev_set[DEV_CMP_PASS] = i_comparator_pass_flag;
        dev_set[DEV_CMP_UNDER] = i_comparator_under_flag;
        dev_set[DEV_LIM_UNDER] = i_limiter_under_flag;
        dev_set[DEV_LIM_OVER] = i_limiter_over_flag;
        dev_set[DEV_EXT_OFF] = i_external_output_off_flag;
        dev_set[DEV_EXT_TRIG] = i_external_trigger_flag;
        dev_set[DEV_CAL_DONE] = i_calibration_done_flag;
        dev_clr[DEV_CAL_DONE] = i_calibration_start;
        dev_set[DEV_SCAN_DONE] = i_scan_done_flag;
        dev_clr[DEV_SCAN_DONE] = i_scan_start;
        // burst steps are too fast to report one by one
        dev_set[DEV_STEP_DONE] = i_scan_step_done_flag && i_trigger_hold && !i_burst_active;
        dev_clr[DEV_STEP_DONE] = i_step_start || i_scan_start || i_scan_stop;
        dev_set[DEV_MEAS_DONE] = i_measure_done_flag;
        dev_clr[DEV_MEAS_DONE] = i_measure_start || i_measure_data_read;
    end

    // device event latch; state bits are levels and follow their cause
    always_comb
    begin
        dev_next = dev_reg & ~dev_clr;
        if (i_clear_status || i_dev_read)
        begin
            dev_next = DEV_RESET;
        end
        dev_next = dev_next | dev_set;
        dev_next[DEV_PAUSED] = (i_op_state == SEVR_SUSPEND);
        dev_next[DEV_OUT_ACTIVE] = (i_op_state == SEVR_OPERATE);
        dev_next[DEV_BUF_FULL] = i_buffer_full_flag;
    end

    // error sets; conditions latch and stay after the cause goes away
    always_comb
    begin
        err_set = '0;
        err_set[ERR_POWERUP_SELFTEST] = i_powerup_selftest_fail;
        err_set[ERR_SELFTEST] = i_selftest_fail;
        err_set[ERR_OVERLOAD] = i_overload;
        err_set[ERR_FAN_STOP] = i_fan_stop;
        err_set[ERR_OVERHEAT] = i_overheat;
        err_set[ERR_SOURCE] = i_source_fault;
        err_set[ERR_CALC] = i_calc_error;
        err_set[ERR_RANGE] = i_over_range;
        err_set[ERR_ARG] = i_arg_error;
        err_set[ERR_EXEC] = i_exec_error;
        err_set[ERR_SYNTAX] = i_syntax_error;
        err_set[ERR_UNKNOWN] = i_unknown_command;
    end

    // error log: reading does not clear it
    always_comb
    begin
        err_next = err_reg;
        if (i_clear_status)
        begin
            err_next = ERR_RESET;
        end
        err_next = err_next | err_set;
    end

    // enable masks: writes load the value, so zero clears
    always_comb
    begin
        std_mask_next = std_mask_reg;
        dev_mask_next = dev_mask_reg;
        if (i_std_mask_wr)
        begin
            std_mask_next = i_std_mask_data;
        end
        if (i_dev_mask_wr)
        begin
            dev_mask_next = i_dev_mask_data;
        end
    end

    // query answers capture the value before the read clears it
    always_comb
    begin
        std_rd_next = std_rd_reg;
        dev_rd_next = dev_rd_reg;
        err_rd_next = err_rd_reg;
        if (i_std_read)
        begin
            std_rd_next = std_reg;
        end
        if (i_dev_read)
        begin
            dev_rd_next = dev_reg;
        end
        if (i_err_read)
        begin
            err_rd_next = err_reg;
        end
    end

    // summaries from next values so they line up with the registered words
    always_comb
    begin
        dsum_next = sevr_summary(dev_next, dev_mask_next);
        ssum_next = sevr_summary({8'h00, std_next}, {8'h00, std_mask_next});
    end

    // standard event word; power-on is the async reset
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            std_reg <= STD_RESET;
        end
        else
        begin
            std_reg <= std_next;
        end
    end

    // device event word; level bits settle one edge after release
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            dev_reg <= DEV_RESET;
        end
        else
        begin
            dev_reg <= dev_next;
        end
    end

    // error log; only power-on and clear-status empty it
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            err_reg <= ERR_RESET;
        end
        else
        begin
            err_reg <= err_next;
        end
    end

    // enable masks start cleared at power-on
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            std_mask_reg <= '0;
            dev_mask_reg <= '0;
        end
        else
        begin
            std_mask_reg <= std_mask_next;
            dev_mask_reg <= dev_mask_next;
        end
    end

    // query answers hold until the next read of the same word
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            std_rd_reg <= '0;
            dev_rd_reg <= '0;
            err_rd_reg <= '0;
        end
        else
        begin
            std_rd_reg <= std_rd_next;
            dev_rd_reg <= dev_rd_next;
            err_rd_reg <= err_rd_next;
        end
    end

    // summaries registered so the status byte never glitches
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            dsum_reg <= 1'h0;
            ssum_reg <= 1'h0;
        end
        else
        begin
            dsum_reg <= dsum_next;
            ssum_reg <= ssum_next;
        end
    end

    // outputs straight from flip-flops
    always_comb
    begin
        o_std_rdata = std_rd_reg;
        o_dev_rdata = dev_rd_reg;
        o_err_rdata = err_rd_reg;
        o_standard_event_reg = std_reg;
        o_device_event_register = dev_reg;
        o_error_log = err_reg;
        o_std_mask = std_mask_reg;
        o_dev_mask = dev_mask_reg;
        o_device_summary_bit = dsum_reg;
        o_standard_summary_bit = ssum_reg;
        o_status_byte_part = 8'h00;
        o_status_byte_part[STB_DEV_SUM] = dsum_reg;
        o_status_byte_part[STB_STD_SUM] = ssum_reg;
    end
endmodule : sevr_status_event_registers

`default_nettype wire

// ### sevr_pkg.sv
// package for the status event register bank: bit positions, widths, reset values
package sevr_pkg;
    localparam int SEVR_STD_W = 8;
    localparam int SEVR_DEV_W = 16;
    localparam int SEVR_ERR_W = 16;
    // standard event bit positions
    localparam int STD_ALL_DONE = 0;
    localparam int STD_HW_FAULT = 3;
    localparam int STD_NOT_RUNNABLE = 4;
    localparam int STD_BAD_SPELLING = 5;
    localparam int STD_POWER_CYCLE = 7;
    // device event bit positions
    localparam int DEV_CMP_ABOVE = 0;
    localparam int DEV_CMP_PASS = 1;
    localparam int DEV_CMP_UNDER = 2;
    localparam int DEV_PAUSED = 5;
    localparam int DEV_LIM_UNDER = 6;
    localparam int DEV_LIM_OVER = 7;
    localparam int DEV_EXT_OFF = 8;
    localparam int DEV_EXT_TRIG = 9;
    localparam int DEV_BUF_FULL = 10;
    localparam int DEV_OUT_ACTIVE = 11;
    localparam int DEV_CAL_DONE = 12;
    localparam int DEV_SCAN_DONE = 13;
    localparam int DEV_STEP_DONE = 14;
    localparam int DEV_MEAS_DONE = 15;
    // error bit positions
    localparam int ERR_POWERUP_SELFTEST = 0;
    localparam int ERR_SELFTEST = 1;
    localparam int ERR_OVERLOAD = 3;
    localparam int ERR_FAN_STOP = 4;
    localparam int ERR_OVERHEAT = 5;
    localparam int ERR_SOURCE = 6;
    localparam int ERR_CALC = 9;
    localparam int ERR_RANGE = 10;
    localparam int ERR_ARG = 12;
    localparam int ERR_EXEC = 13;
    localparam int ERR_SYNTAX = 14;
    localparam int ERR_UNKNOWN = 15;
    // status byte bit positions
    localparam int STB_DEV_SUM = 3;
    localparam int STB_STD_SUM = 5;
    // reset values
    localparam logic [7:0] STD_RESET = 8'h00;
    localparam logic [15:0] DEV_RESET = 16'h0000;
    localparam logic [15:0] ERR_RESET = 16'h0000;
    // operating state codes on the input port
    typedef enum logic [1:0] {SEVR_STANDBY, SEVR_OPERATE, SEVR_SUSPEND} sevr_state_t;
endpackage : sevr_pkg

// ### sevr_props.sv
// checker for the status event register bank
`timescale 1ns/10ps
`default_nettype none
module sevr_props
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_clear_status,
    input wire logic i_std_read,
    input wire logic i_dev_read,
    input wire logic i_err_read,
    input wire logic i_std_mask_wr,
    input wire logic [7:0] i_std_mask_data,
    input wire logic i_bad_spelling_flag,
    input wire logic i_measure_done_flag,
    input wire sevr_pkg::sevr_state_t i_op_state,
    input wire logic [7:0] o_standard_event_reg,
    input wire logic [15:0] o_device_event_register,
    input wire logic [15:0] o_error_log,
    input wire logic [7:0] o_std_mask,
    input wire logic [15:0] o_dev_mask,
    input wire logic o_device_summary_bit,
    input wire logic o_standard_summary_bit,
    input wire logic [7:0] o_status_byte_part
);
    import sevr_pkg::*;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // a query with no fresh spelling event must drop the bit
    sequence s_std_query;
        i_std_read && !i_bad_spelling_flag;
    endsequence
    sequence s_spell_gone;
        !o_standard_event_reg[5];
    endsequence
    property p_spell;
        i_bad_spelling_flag |=> o_standard_event_reg[5];
    endproperty
    a_spell: assert property (p_spell) else $error("spelling bit not set");
    property p_std_query;
        s_std_query |=> s_spell_gone;
    endproperty
    a_std_query: assert property (p_std_query) else $error("query left bit set");
    property p_mask0;
        i_std_mask_wr && i_std_mask_data == 8'h00 |=> o_std_mask == 8'h00;
    endproperty
    a_mask0: assert property (p_mask0) else $error("std mask not cleared");
    // state bits 5 and 11 follow the state one cycle later
    property p_state;
        i_rst_n |=> o_device_event_register[5] == ($past(i_op_state) == SEVR_SUSPEND)
            && o_device_event_register[11] == ($past(i_op_state) == SEVR_OPERATE);
    endproperty
    a_state: assert property (p_state) else $error("state bits wrong");
    property p_set_wins;
        i_dev_read && i_measure_done_flag |=> o_device_event_register[15];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on read");
    property p_err_read;
        i_err_read && !i_clear_status |=> (o_error_log & $past(o_error_log)) == $past(o_error_log);
    endproperty
    a_err_read: assert property (p_err_read) else $error("error log lost bits");
    property p_sum;
        o_device_summary_bit == |(o_device_event_register & o_dev_mask)
            && o_standard_summary_bit == |(o_standard_event_reg & o_std_mask);
    endproperty
    a_sum: assert property (p_sum) else $error("summary mismatch");
    property p_stb;
        o_status_byte_part == {2'h0, o_standard_summary_bit, 1'h0, o_device_summary_bit, 3'h0};
    endproperty
    a_stb: assert property (p_stb) else $error("status byte wrong");
endmodule : sevr_props
bind sevr_status_event_registers sevr_props u_props
(
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_clear_status(i_clear_status),
    .i_std_read(i_std_read), .i_dev_read(i_dev_read), .i_err_read(i_err_read),
    .i_std_mask_wr(i_std_mask_wr), .i_std_mask_data(i_std_mask_data),
    .i_bad_spelling_flag(i_bad_spelling_flag), .i_measure_done_flag(i_measure_done_flag),
    .i_op_state(i_op_state), .o_standard_event_reg(o_standard_event_reg),
    .o_device_event_register(o_device_event_register), .o_error_log(o_error_log),
    .o_std_mask(o_std_mask), .o_dev_mask(o_dev_mask),
    .o_device_summary_bit(o_device_summary_bit),
    .o_standard_summary_bit(o_standard_summary_bit),
    .o_status_byte_part(o_status_byte_part)
);
`default_nettype wire

// ### sevr_host_model.sv
// query and mask-write issuer standing in for the remote controller
`timescale 1ns/10ps
`default_nettype none
module sevr_host_model
(
    input wire logic i_core_clk,
    output logic [5:0] o_cmd,
    output logic [15:0] o_data
);
    // one-hot: clear, std read, dev read, err read, std mask, dev mask
    initial
    begin
        o_cmd = 6'h00;
        o_data = 16'h0000;
    end
    // caller stands at a falling edge; strobe spans exactly one rising edge
    task automatic issue(input int op, input logic [15:0] d);
        o_cmd = 6'h01 << op;
        o_data = d;
        @(negedge i_core_clk);
        o_cmd = 6'h00;
        o_data = ~d; // stale data never looks valid
    endtask : issue
endmodule : sevr_host_model
`default_nettype wire

// ### sevr_status_event_registers_tb.sv
// self-checking bench for the status event register bank
`timescale 1ns/10ps
`default_nettype none
module sevr_status_event_registers_tb;
    import sevr_pkg::*;
    logic clk;
    logic rst_n;
    logic [36:0] src;
    sevr_state_t op_state;
    logic [5:0] cmd;
    logic [15:0] hd;
    logic [7:0] std_rd, std_reg, std_mask, stb;
    logic dsum, ssum;
    logic [15:0] dev_rd, err_rd, dev_reg, err_log, dev_mask;
    int n_mismatch = 0;
    int checks_done = 0;
    int sp[5] = '{0, 3, 4, 5, 7};
    int di[10] = '{5, 6, 7, 8, 9, 10, 11, 14, 17, 23};
    int dp[10] = '{0, 1, 2, 6, 7, 8, 9, 12, 13, 15};
    int ep[12] = '{0, 1, 3, 4, 5, 6, 9, 10, 12, 13, 14, 15};
    sevr_host_model u_host (.i_core_clk(clk), .o_cmd(cmd), .o_data(hd));
    // sources sit in one vector so tables can pulse them by index
    sevr_status_event_registers u_dut
    (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_clear_status(cmd[0]), .i_std_read(cmd[1]),
        .i_dev_read(cmd[2]), .i_err_read(cmd[3]), .i_std_mask_wr(cmd[4]),
        .i_std_mask_data(hd[7:0]), .i_dev_mask_wr(cmd[5]), .i_dev_mask_data(hd),
        .i_all_done_flag(src[0]), .i_hardware_fault_flag(src[1]),
        .i_command_not_runnable_flag(src[2]), .i_bad_spelling_flag(src[3]),
        .i_power_cycle_flag(src[4]), .i_comparator_above_flag(src[5]),
        .i_comparator_pass_flag(src[6]), .i_comparator_under_flag(src[7]),
        .i_op_state(op_state), .i_limiter_under_flag(src[8]), .i_limiter_over_flag(src[9]),
        .i_external_output_off_flag(src[10]), .i_external_trigger_flag(src[11]),
        .i_buffer_full_flag(src[12]), .i_calibration_start(src[13]),
        .i_calibration_done_flag(src[14]), .i_scan_start(src[15]), .i_scan_stop(src[16]),
        .i_scan_done_flag(src[17]), .i_step_start(src[18]), .i_scan_step_done_flag(src[19]),
        .i_trigger_hold(src[20]), .i_burst_active(src[21]), .i_measure_start(src[22]),
        .i_measure_done_flag(src[23]), .i_measure_data_read(src[24]),
        .i_powerup_selftest_fail(src[25]), .i_selftest_fail(src[26]), .i_overload(src[27]),
        .i_fan_stop(src[28]), .i_overheat(src[29]), .i_source_fault(src[30]),
        .i_calc_error(src[31]), .i_over_range(src[32]), .i_arg_error(src[33]),
        .i_exec_error(src[34]), .i_syntax_error(src[35]), .i_unknown_command(src[36]),
        .o_std_rdata(std_rd), .o_dev_rdata(dev_rd), .o_err_rdata(err_rd),
        .o_standard_event_reg(std_reg), .o_device_event_register(dev_reg),
        .o_error_log(err_log), .o_std_mask(std_mask), .o_dev_mask(dev_mask),
        .o_device_summary_bit(dsum), .o_standard_summary_bit(ssum), .o_status_byte_part(stb)
    );
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // one-cycle source pulse, entered and left at a falling edge
    task automatic pulse(input int k);
        src[k] = 1'b1;
        @(negedge clk);
        src[k] = 1'b0;
    endtask : pulse
    task automatic wrap_up;
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // the run needs about 90 cycles; the 4000-cycle limit allows over forty times that
    initial
    begin
        #400000;
        n_mismatch++;
        wrap_up();
    end
    initial
    begin
        logic [15:0] e;
        rst_n = 1'b0;
        src = '0;
        op_state = SEVR_STANDBY;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk("std", 16'h0, std_reg);
        chk("dev", 16'h0, dev_reg);
        chk("smask", 16'h0, std_mask);
        chk("dmask", 16'h0, dev_mask);
        foreach (sp[i])
        begin
            pulse(i);
            u_host.issue(1, 16'h0);
            chk("std_rd", 16'h1 << sp[i], std_rd);
            chk("std_clr", 16'h0, std_reg);
        end
        u_host.issue(4, 16'h0020);
        pulse(3);
        chk("stb_std", 16'h0020, stb);
        chk("ssum", 16'h1, {15'h0, ssum});
        u_host.issue(0, 16'h0);
        chk("stb_cls", 16'h0, stb);
        chk("ssum_cls", 16'h0, {15'h0, ssum});
        u_host.issue(4, 16'h0);
        chk("smask0", 16'h0, std_mask);
        foreach (dp[i])
        begin
            pulse(di[i]);
            u_host.issue(2, 16'h0);
            chk("dev_rd", 16'h1 << dp[i], dev_rd);
            chk("dev_clr", 16'h0, dev_reg);
        end
        op_state = SEVR_OPERATE;
        @(negedge clk);
        chk("operate", 16'h0800, dev_reg);
        op_state = SEVR_SUSPEND;
        src[12] = 1'b1;
        @(negedge clk);
        u_host.issue(2, 16'h0);
        chk("levels", 16'h0420, dev_reg);
        src[12] = 1'b0;
        op_state = SEVR_STANDBY;
        @(negedge clk);
        chk("levels_off", 16'h0, dev_reg);
        u_host.issue(5, 16'h8000);
        pulse(23);
        chk("stb_dev", 16'h0008, stb);
        chk("dsum", 16'h1, {15'h0, dsum});
        pulse(24);
        chk("meas_read", 16'h0, dev_reg);
        chk("dsum_rd", 16'h0, {15'h0, dsum});
        pulse(23);
        pulse(22);
        chk("meas_start", 16'h0, dev_reg);
        src[23] = 1'b1;
        u_host.issue(2, 16'h0);
        src[23] = 1'b0;
        chk("set_wins", 16'h8000, dev_reg);
        u_host.issue(5, 16'h0);
        chk("dmask0", 16'h0, dev_mask);
        u_host.issue(0, 16'h0);
        src[20] = 1'b1;
        pulse(19);
        chk("step_hold", 16'h4000, dev_reg);
        pulse(18);
        chk("step_start", 16'h0, dev_reg);
        src[21] = 1'b1;
        pulse(19);
        chk("step_burst", 16'h0, dev_reg);
        src[21] = 1'b0;
        pulse(19);
        pulse(17);
        pulse(16);
        chk("scan_stop", 16'h2000, dev_reg);
        pulse(15);
        chk("scan_start", 16'h0, dev_reg);
        pulse(14);
        pulse(13);
        chk("cal_start", 16'h0, dev_reg);
        src[20] = 1'b0;
        e = 16'h0;
        foreach (ep[i])
        begin
            pulse(25 + i);
            e[ep[i]] = 1'b1;
            chk("err_set", e, err_log);
        end
        u_host.issue(3, 16'h0);
        chk("err_rd", 16'hf67b, err_rd);
        chk("err_keep", 16'hf67b, err_log);
        u_host.issue(0, 16'h0);
        chk("err_cls", 16'h0, err_log);
        wrap_up();
    end
endmodule : sevr_status_event_registers_tb
`default_nettype wire
